/* File: bench/lfr_host.sv */
// Purpose: two-wire host model
// Assumes: SDA pulled up, device only pulls low
// Notes: half bit is twelve system clocks
`default_nettype none
module lfr_host (
  input  wire logic clk_sys_in,
  input  wire logic sda_rd_in,
  output logic      scl_out,
  output logic      sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic hp();
    repeat (12) @(negedge clk_sys_in);
  endtask : hp
  task automatic sl(input logic v);
    scl_out = v;
  endtask : sl
  task automatic st();
    sda_out = 1'b1;
    hp();
    scl_out = 1'b1;
    hp();
    sda_out = 1'b0;
    hp();
    scl_out = 1'b0;
  endtask : st
  task automatic sp();
    sda_out = 1'b0;
    hp();
    scl_out = 1'b1;
    hp();
    sda_out = 1'b1;
    hp();
  endtask : sp
  task automatic xb(input logic [7:0] d, output logic [7:0] q, output logic a);
    for (int i = 8; i >= 0; i--)
    begin
      sda_out = (i > 0) ? d[i - 1] : 1'b1;
      hp();
      scl_out = 1'b1;
      hp();
      if (i > 0) q[i - 1] = sda_rd_in;
      else a = sda_rd_in;
      scl_out = 1'b0;
    end
  endtask : xb
endmodule : lfr_host
`default_nettype wire

/* File: bench/lfr_props.sv */
// Purpose: port assertions of the LED controller
// Assumes: SCL half periods of ten clocks or more
// Notes: bound to lfr_top
`default_nettype none
module lfr_props (
  input wire logic                      clk_sys_in,
  input wire logic                      rst_in,
  input wire logic                      scl_in,
  input wire logic                      sda_out,
  input wire logic                      sda_oe_out,
  input wire logic                      sync_out,
  input wire logic                      sync_oe_out,
  input wire lfr_pkg::lfr_chan_s [11:0] chan_out,
  input wire logic                      range_hi_out,
  input wire logic                      standby_out
);
  wire logic [11:0] drv;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  for (genvar i = 0; i < 12; i++)
  begin : g_ch
    assign drv[i] = chan_out[i].drive;
    property p_units; chan_out[i].units <= 6'h30; endproperty
    a_units: assert property (p_units) else $error("units over full scale");
  end
  sequence s_stby; standby_out [*3]; endsequence
  property p_stby_off; s_stby |-> drv == 12'h000; endproperty
  a_stby_off: assert property (p_stby_off) else $error("drive in standby");
  property p_sda_hold; $changed(sda_oe_out) |-> !scl_in; endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("data moved in clock high");
  property p_sda_low; !sda_out; endproperty
  a_sda_low: assert property (p_sda_low) else $error("data driven high");
  property p_sync_idle; !sync_oe_out |-> !sync_out; endproperty
  a_sync_idle: assert property (p_sync_idle) else $error("sync level as input");
  property p_sync_tgl; sync_out |=> !sync_out; endproperty
  a_sync_tgl: assert property (p_sync_tgl) else $error("sync clock stuck");
  property p_sync_dir; $changed(sync_oe_out) |-> !scl_in; endproperty
  a_sync_dir: assert property (p_sync_dir) else $error("sync dir moved");
  property p_rst_vals; $fell(rst_in) |-> sync_oe_out && standby_out && !range_hi_out; endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset state");
  property p_range_chg; $changed(range_hi_out) |-> !scl_in; endproperty
  a_range_chg: assert property (p_range_chg) else $error("range moved");
endmodule : lfr_props
bind lfr_top lfr_props u_props (.clk_sys_in, .rst_in, .scl_in, .sda_out, .sda_oe_out,
  .sync_out, .sync_oe_out, .chan_out, .range_hi_out, .standby_out);
`default_nettype wire

/* File: bench/lfr_top_tb.sv */
// Purpose: self-checking bench of the LED controller
// Assumes: short tick and shutdown counts
// Notes: random data from an LFSR seeded 88
`default_nettype none
module lfr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in, rst_in, sync_clk_in, ext_pwm_in, sda_out, sda_oe_out, sync_out;
  logic sync_oe_out, range_hi_out, standby_out, scl_w, sda_h, ack, s0;
  logic [1:0] addr_sel_in;
  logic [7:0] lf, q, c, s;
  logic [5:0] r;
  lfr_pkg::lfr_chan_s [11:0] chan_out;
  int err_total = 0, comparisons = 0, cyc = 0;
  wire logic sda_w = sda_oe_out ? sda_out & sda_h : sda_h;
  initial
  begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  initial
  begin
    sync_clk_in = 1'b0;
    #3;
    forever #6 sync_clk_in = ~sync_clk_in;
  end
  lfr_top #(.FINE_CYC(4), .LINK_DIV(4), .SCL_LOW_CYC(50)) uut (.clk_sys_in, .rst_in,
    .sync_clk_in, .scl_in(scl_w), .sda_in(sda_w), .sda_out, .sda_oe_out, .addr_sel_in,
    .ext_pwm_in, .sync_out, .sync_oe_out, .chan_out, .range_hi_out, .standby_out);
  lfr_host host (.clk_sys_in, .sda_rd_in(sda_w), .scl_out(scl_w), .sda_out(sda_h));
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nx
  task automatic chk(input logic [7:0] sv, input logic [7:0] ev);
    comparisons++;
    if (sv !== ev)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, sv, ev);
    end
  endtask : chk
  task automatic cb(input logic sv, input logic ev);
    chk({7'h00, sv}, {7'h00, ev});
  endtask : cb
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.st();
    host.xb({5'h12, addr_sel_in, 1'b0}, q, ack);
    cb(ack, 1'b0);
    host.xb({2'b00, a}, q, ack);
    host.xb(d, q, ack);
    host.sp();
  endtask : wr
  task automatic rd(input logic [5:0] a);
    host.st();
    host.xb({5'h12, addr_sel_in, 1'b0}, q, ack);
    host.xb({2'b00, a}, q, ack);
    host.st();
    host.xb({5'h12, addr_sel_in, 1'b1}, q, ack);
    host.xb(8'hFF, q, ack);
    host.sp();
  endtask : rd
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      give_verdict();
    end
  end
  initial
  begin
    rst_in = 1'b1;
    ext_pwm_in = 1'b0;
    lf = nx(8'h58);
    addr_sel_in = lf[1:0];
    repeat (6) @(negedge clk_sys_in);
    rst_in = 1'b0;
    cb(standby_out, 1'b1);
    cb(range_hi_out, 1'b0);
    cb(sync_oe_out, 1'b1);
    rd(6'h02);
    chk(q, 8'h01);
    host.st();
    host.xb({5'h13, addr_sel_in, 1'b0}, q, ack);
    host.sp();
    cb(ack, 1'b1);
    $display("reset test done");
    for (int k = 0; k < 6; k++)
    begin
      lf = nx(lf);
      r = (k == 0) ? 6'h26 : (k == 1) ? 6'h3F : lf[5:0] | 6'h01;
      lf = nx(lf);
      wr(r, lf);
      rd(r);
      chk(q, (r > 6'h26) ? 8'h00 : (r == 6'h26) ? lf & 8'h0F : lf);
    end
    $display("register test done");
    for (int p = 0; p < 2; p++)
    begin
      wr(6'h00, p[0] ? 8'h5C : 8'h54);
      cb(standby_out, 1'b0);
      cb(range_hi_out, 1'b1);
      s0 = sync_out;
      @(negedge clk_sys_in);
      cb(sync_out, ~s0);
      host.sl(1'b0);
      repeat (60) @(negedge clk_sys_in);
      cb(standby_out, p[0]);
      host.sl(1'b1);
      repeat (8) @(negedge clk_sys_in);
    end
    $display("control test done");
    wr(6'h16, 8'h21);
    wr(6'h26, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      lf = nx(lf);
      c = (k == 0) ? 8'hFF : (k == 1) ? 8'hBE : lf;
      wr(6'h1A, c);
      s = 8'h00;
      repeat (4)
      begin
        @(negedge clk_sys_in);
        s = s + {2'b00, chan_out[0].units};
      end
      chk(s, (c >= 8'hBF) ? 8'hC0 : c + 8'h01);
    end
    cb(chan_out[1].drive, 1'b0);
    cb(chan_out[2].drive, 1'b1);
    wr(6'h26, 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      ext_pwm_in = k[0];
      repeat (6) @(negedge clk_sys_in);
      cb(chan_out[0].drive, k[0]);
    end
    wr(6'h05, 8'h00);
    wr(6'h02, 8'hFF);
    wr(6'h16, 8'h22);
    wr(6'h00, 8'hB0);
    repeat (300) @(negedge clk_sys_in);
    cb(chan_out[0].drive, 1'b1);
    cb(chan_out[1].drive, 1'b0);
    wr(6'h00, 8'h10);
    cb(chan_out[0].drive, 1'b0);
    wr(6'h00, 8'h20);
    cb(sync_oe_out, 1'b0);
    cb(standby_out, 1'b1);
    $display("channel test done");
    give_verdict();
  end
endmodule : lfr_top_tb
`default_nettype wire

/* File: verilog/lfr_consts.svh */
// Purpose: register map, field positions, reset values and timing figures
// Assumes: byte-wide registers reached over the two-wire serial port
// Notes: fine tick is the common time base of all flash logic
`ifndef LFR_CONSTS_SVH
`define LFR_CONSTS_SVH
`define LFR_REG_CHIP       6'h00
`define LFR_REG_GRP_BASE   6'h01
`define LFR_GRP_STRIDE     6'h05
`define LFR_GOFS_PERIOD    6'h00
`define LFR_GOFS_ON_TIMER_ONE      6'h01
`define LFR_GOFS_ON_TIMER_TWO      6'h02
`define LFR_GOFS_RAMP      6'h03
`define LFR_GOFS_DELAY     6'h04
`define LFR_REG_SCALE      6'h15
`define LFR_REG_MODE_BASE  6'h16
`define LFR_REG_CURT_BASE  6'h1A
`define LFR_REG_EXTERNAL_PWM_INPUT      6'h26
`define LFR_REG_LAST       6'h26
`define LFR_REG_COUNT      39
`define LFR_BIT_AUTO       7
`define LFR_BIT_CLKOEN     6
`define LFR_BIT_CLKDIR     5
`define LFR_BIT_SOFTDN     4
`define LFR_BIT_PDEN       3
`define LFR_BIT_IMAX       2
`define LFR_RST_ZERO       8'h00
`define LFR_RST_TON        8'h01
`define LFR_RST_CURT       8'h4F
`define LFR_EXTERNAL_PWM_INPUT_MASK     8'h0F
`define LFR_CURT_MAX       8'hBF
`define LFR_I2C_ADDR_BASE  7'h48
`define LFR_CLK_MHZ        50
`define LFR_FINE_NS        62500
`define LFR_SCL_LOW_US     350
`define LFR_PERIOD_MS      128
`define LFR_RAMP_MS        128
`define LFR_RAMP0_MS       2
`define LFR_FINE_CYC       (`LFR_CLK_MHZ * `LFR_FINE_NS / 1000)
`define LFR_SCL_LOW_CYC    (`LFR_SCL_LOW_US * `LFR_CLK_MHZ)
`define LFR_PERIOD_FINE    (`LFR_PERIOD_MS * 1000000 / `LFR_FINE_NS)
`define LFR_TON_FINE       (`LFR_PERIOD_FINE / 256)
`define LFR_RAMP_STEP      (`LFR_RAMP_MS * 1000000 / `LFR_FINE_NS / 256)
`define LFR_RAMP0_INC      (256 / (`LFR_RAMP0_MS * 1000000 / `LFR_FINE_NS))
`endif

/* File: verilog/lfr_group.sv */
// Purpose: flash sequencer and ramp engine for one group of three channels
// Assumes: tick_in is a one-cycle pulse every fine tick
// Notes: produces three thread brightness levels 0..255
`include "lfr_consts.svh"
`default_nettype none
module lfr_group
(
  input  wire logic                   clk_sys_in,
  input  wire logic                   rst_in,
  input  wire logic                   tick_in,
  input  wire logic                   run_in,
  input  wire lfr_pkg::lfr_grp_cfg_s  cfg_in,
  input  wire lfr_pkg::lfr_tmd_e      tmd_in,
  output logic [2:0][7:0]             level_out
);
  logic [7:0]          p1;
  logic [15:0]         m1;
  logic [15:0]         m2;
  logic [19:0]         per_len;
  logic [19:0]         on_timer_one;
  logic [19:0]         on_timer_two;
  logic [19:0]         dly_len;
  logic [19:0]         s2;
  logic [20:0]         e2;
  logic [20:0]         e3;
  logic                ovr;
  logic                wrap;
  logic [2:0]          win;
  lfr_pkg::lfr_gst_e   st_q;
  logic [19:0]         t_q;

  function automatic logic [8:0] step_len(input logic [3:0] code, input logic [1:0] sc);
    logic [8:0] b;
    b = 9'(code) * 9'(`LFR_RAMP_STEP);
    unique case (sc)
      2'b00: step_len = b;
      2'b01: step_len = b << 1;
      2'b10: step_len = b << 2;
      2'b11: step_len = b >> 3;
    endcase
  endfunction : step_len

  function automatic logic [7:0] scurve(input logic [7:0] l);
    logic [7:0]  r;
    logic [15:0] q;
    r = l[7] ? ~l : l;
    q = 16'(r) * 16'(r);
    scurve = l[7] ? ~q[14:7] : q[14:7];
  endfunction : scurve

  assign p1      = {1'b0, cfg_in.period[6:0]} + 8'h01;
  assign per_len = 20'(p1) * 20'(`LFR_PERIOD_FINE);
  assign m1      = 16'(cfg_in.on_timer_one) * 16'(p1);
  assign m2      = 16'(cfg_in.on_timer_two) * 16'(p1);
  assign on_timer_one    = 20'(m1) * 20'(`LFR_TON_FINE);
  assign on_timer_two    = 20'(m2) * 20'(`LFR_TON_FINE);
  assign dly_len = 20'(cfg_in.delay) * 20'(`LFR_PERIOD_FINE);
  always_comb
  begin
    unique case (tmd_in)
      lfr_pkg::TMD_M1: s2 = 20'h00000;
      lfr_pkg::TMD_M2: s2 = on_timer_one;
      lfr_pkg::TMD_M3: s2 = per_len >> 1;
      lfr_pkg::TMD_M4: s2 = (on_timer_two > per_len) ? 20'h00000 : per_len - on_timer_two;
    endcase
  end
  assign e2     = {1'b0, s2} + {1'b0, on_timer_two};
  assign e3     = {1'b0, on_timer_one} + {1'b0, on_timer_two};
  assign ovr    = e3 > {1'b0, per_len};
  assign win[0] = t_q < on_timer_one;
  assign win[1] = (t_q >= s2) && ({1'b0, t_q} < e2);
  assign win[2] = (t_q >= on_timer_one) && ({1'b0, t_q} < e3);
  assign wrap   = (st_q == lfr_pkg::GS_RUN) && tick_in && ((t_q + 20'h00001) >= per_len);

  // Delay, then repeat the flash period
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || !run_in)
    begin
      st_q <= lfr_pkg::GS_IDLE;
      t_q  <= 20'h00000;
    end
    else
    begin
      unique case (st_q)
        lfr_pkg::GS_IDLE:
        begin
          st_q <= lfr_pkg::GS_DELAY;
          t_q  <= 20'h00000;
        end
        lfr_pkg::GS_DELAY:
        begin
          if (t_q >= dly_len)
          begin
            st_q <= lfr_pkg::GS_RUN;
            t_q  <= 20'h00000;
          end
          else if (tick_in)
            t_q <= t_q + 20'h00001;
        end
        lfr_pkg::GS_RUN:
        begin
          if (wrap)
            t_q <= 20'h00000;
          else if (tick_in)
            t_q <= t_q + 20'h00001;
        end
        default:
          st_q <= lfr_pkg::GS_IDLE;
      endcase
    end
  end

  for (genvar i = 0; i < 3; i++)
  begin : g_thr
    logic [7:0] lv_q;
    logic [8:0] c_q;
    logic       up;
    logic [8:0] len;
    assign up  = (st_q == lfr_pkg::GS_RUN) && win[i];
    assign len = up ? step_len(cfg_in.ramp[3:0], cfg_in.scale)
                    : step_len(cfg_in.ramp[7:4], cfg_in.scale);
    always_ff @(posedge clk_sys_in)
    begin
      if (rst_in || st_q != lfr_pkg::GS_RUN || (wrap && ovr))
      begin
        lv_q <= 8'h00;
        c_q  <= 9'h000;
      end
      else if (tick_in)
      begin
        if ((up && lv_q != 8'hFF) || (!up && lv_q != 8'h00))
        begin
          if (len == 9'h000)
          begin
            c_q  <= 9'h000;
            if (up)
              lv_q <= (lv_q > 8'(255 - `LFR_RAMP0_INC)) ? 8'hFF : lv_q + 8'(`LFR_RAMP0_INC);
            else
              lv_q <= (lv_q < 8'(`LFR_RAMP0_INC)) ? 8'h00 : lv_q - 8'(`LFR_RAMP0_INC);
          end
          else if (c_q + 9'h001 >= len)
          begin
            c_q  <= 9'h000;
            lv_q <= up ? lv_q + 8'h01 : lv_q - 8'h01;
          end
          else
            c_q <= c_q + 9'h001;
        end
        else
          c_q <= 9'h000;
      end
    end
    always_ff @(posedge clk_sys_in)
    begin
      if (rst_in)
        level_out[i] <= 8'h00;
      else
        level_out[i] <= cfg_in.period[7] ? lv_q : scurve(lv_q);
    end
  end
endmodule : lfr_group
`default_nettype wire

/* File: verilog/lfr_pkg.sv */
// Purpose: shared types of the LED flash and ramp controller
// Assumes: nothing
// Notes: enum orders match the register field codes
`default_nettype none
package lfr_pkg;
  typedef enum logic [1:0] {TMD_M1, TMD_M2, TMD_M3, TMD_M4} lfr_tmd_e;
  typedef enum logic [2:0] {CM_OFF, CM_ON, CM_T1, CM_T2, CM_T3} lfr_cmode_e;
  typedef enum logic [1:0] {GS_IDLE, GS_DELAY, GS_RUN} lfr_gst_e;
  typedef enum logic [2:0] {IS_IDLE, IS_DEV, IS_REG, IS_WR, IS_ACK, IS_RD, IS_RACK} lfr_ist_e;
  typedef struct packed {
    logic       drive;
    logic [5:0] units;
  } lfr_chan_s;
  typedef struct packed {
    logic [7:0] period;
    logic [7:0] on_timer_one;
    logic [7:0] on_timer_two;
    logic [7:0] ramp;
    logic [7:0] delay;
    logic [1:0] scale;
  } lfr_grp_cfg_s;
endpackage : lfr_pkg
`default_nettype wire

/* File: verilog/lfr_top.sv */
// Purpose: twelve-channel LED flash and ramp controller with serial register port
// Assumes: 50 MHz system clock; sync pin clock is the link domain
// Notes: channel outputs carry a drive enable and current units of 0.5 or 1 mA
`include "lfr_consts.svh"
`default_nettype none
module lfr_top
#(
  parameter int FINE_CYC    = `LFR_FINE_CYC,
  parameter int LINK_DIV    = `LFR_FINE_CYC,
  parameter int SCL_LOW_CYC = `LFR_SCL_LOW_CYC
)
(
  input  wire logic                    clk_sys_in,
  input  wire logic                    rst_in,
  input  wire logic                    sync_clk_in,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe_out,
  input  wire logic [1:0]              addr_sel_in,
  input  wire logic                    ext_pwm_in,
  output logic                         sync_out,
  output logic                         sync_oe_out,
  output lfr_pkg::lfr_chan_s [11:0]    chan_out,
  output logic                         range_hi_out,
  output logic                         standby_out
);
  logic [7:0]               regs_q [0:`LFR_REG_COUNT-1];
  logic [4:0]               sy1_q;
  logic [4:0]               sy2_q;
  logic                     scl_s;
  logic                     sda_s;
  logic                     scl_p_q;
  logic                     sda_p_q;
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     i2c_start;
  logic                     i2c_stop;
  logic [6:0]               own_q;
  lfr_pkg::lfr_ist_e        ist_q;
  lfr_pkg::lfr_ist_e        nxt_q;
  logic [3:0]               bit_q;
  logic [7:0]               sh_q;
  logic [5:0]               ptr_q;
  logic                     wr_q;
  logic [5:0]               wa_q;
  logic [7:0]               wd_q;
  logic [7:0]               rdata;
  logic [7:0]               chip;
  logic                     lrst1_q;
  logic                     lrst2_q;
  logic [31:0]              lcnt_q;
  logic                     ltgl_q;
  logic [2:0]               tsy_q;
  logic [31:0]              fcnt_q;
  logic                     tick_q;
  logic [31:0]              scnt_q;
  logic                     scl_sd_q;
  logic                     stby_q;
  logic [7:0]               pwm_q;
  logic [1:0]               il_q;
  logic [3:0][2:0][7:0]     lvl;
  lfr_pkg::lfr_grp_cfg_s [3:0] cfg;

  function automatic logic [7:0] rst_val(input int idx);
    if (idx >= int'(`LFR_REG_CURT_BASE) && idx < int'(`LFR_REG_EXTERNAL_PWM_INPUT))
      rst_val = `LFR_RST_CURT;
    else if (idx >= int'(`LFR_REG_GRP_BASE) && idx < int'(`LFR_REG_SCALE)
             && ((idx - int'(`LFR_REG_GRP_BASE)) % int'(`LFR_GRP_STRIDE) == 1
             || (idx - int'(`LFR_REG_GRP_BASE)) % int'(`LFR_GRP_STRIDE) == 2))
      rst_val = `LFR_RST_TON;
    else
      rst_val = `LFR_RST_ZERO;
  endfunction : rst_val

  function automatic lfr_pkg::lfr_cmode_e cmode(input logic [7:0] r, input int k);
    logic [2:0] f;
    f = (k == 0) ? {1'b0, r[1:0]} : ((k == 1) ? r[4:2] : r[7:5]);
    if (f[2])
      cmode = lfr_pkg::CM_T3;
    else
      cmode = lfr_pkg::lfr_cmode_e'({1'b0, f[1:0]});
  endfunction : cmode

  assign chip = regs_q[`LFR_REG_CHIP];

  // Two-flop synchronisers for pins
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      sy1_q <= 5'h1F;
      sy2_q <= 5'h1F;
    end
    else
    begin
      sy1_q <= {addr_sel_in, ext_pwm_in, sda_in, scl_in};
      sy2_q <= sy1_q;
    end
  end
  assign scl_s = sy2_q[0];
  assign sda_s = sy2_q[1];

  // Bus edge and condition detection
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      own_q   <= `LFR_I2C_ADDR_BASE;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      own_q   <= `LFR_I2C_ADDR_BASE + {5'h00, sy2_q[4:3]};
    end
  end
  assign scl_rise  = scl_s && !scl_p_q;
  assign scl_fall  = !scl_s && scl_p_q;
  assign i2c_start = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign i2c_stop  = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign rdata     = (ptr_q <= `LFR_REG_LAST) ? regs_q[ptr_q] : 8'h00;

  // Serial slave: address, pointer, write and read bytes
  always_ff @(posedge clk_sys_in)
  begin
    wr_q <= 1'b0;
    if (rst_in || i2c_stop)
    begin
      ist_q      <= lfr_pkg::IS_IDLE;
      nxt_q      <= lfr_pkg::IS_IDLE;
      bit_q      <= 4'h0;
      sh_q       <= 8'h00;
      ptr_q      <= 6'h00;
      wa_q       <= 6'h00;
      wd_q       <= 8'h00;
      sda_oe_out <= 1'b0;
      wr_q       <= 1'b0;
    end
    else if (i2c_start)
    begin
      ist_q      <= lfr_pkg::IS_DEV;
      bit_q      <= 4'h0;
      sda_oe_out <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (ist_q == lfr_pkg::IS_RACK && sda_s)
        ist_q <= lfr_pkg::IS_IDLE;
      else if (ist_q == lfr_pkg::IS_DEV || ist_q == lfr_pkg::IS_REG
               || ist_q == lfr_pkg::IS_WR || ist_q == lfr_pkg::IS_RD)
      begin
        sh_q  <= (ist_q == lfr_pkg::IS_RD) ? sh_q : {sh_q[6:0], sda_s};
        bit_q <= bit_q + 4'h1;
      end
    end
    else if (scl_fall)
    begin
      unique case (ist_q)
        lfr_pkg::IS_DEV:
        begin
          if (bit_q == 4'h8 && sh_q[7:1] == own_q)
          begin
            sda_oe_out <= 1'b1;
            ist_q      <= lfr_pkg::IS_ACK;
            nxt_q      <= sh_q[0] ? lfr_pkg::IS_RD : lfr_pkg::IS_REG;
          end
          else if (bit_q == 4'h8)
            ist_q <= lfr_pkg::IS_IDLE;
        end
        lfr_pkg::IS_REG:
        begin
          if (bit_q == 4'h8)
          begin
            ptr_q      <= sh_q[5:0];
            sda_oe_out <= 1'b1;
            ist_q      <= lfr_pkg::IS_ACK;
            nxt_q      <= lfr_pkg::IS_WR;
          end
        end
        lfr_pkg::IS_WR:
        begin
          if (bit_q == 4'h8)
          begin
            wr_q       <= 1'b1;
            wa_q       <= ptr_q;
            wd_q       <= sh_q;
            ptr_q      <= ptr_q + 6'h01;
            sda_oe_out <= 1'b1;
            ist_q      <= lfr_pkg::IS_ACK;
            nxt_q      <= lfr_pkg::IS_WR;
          end
        end
        lfr_pkg::IS_ACK, lfr_pkg::IS_RACK:
        begin
          bit_q <= 4'h0;
          if (nxt_q == lfr_pkg::IS_RD || ist_q == lfr_pkg::IS_RACK)
          begin
            sh_q       <= rdata;
            sda_oe_out <= !rdata[7];
            ptr_q      <= ptr_q + 6'h01;
            ist_q      <= lfr_pkg::IS_RD;
          end
          else
          begin
            sda_oe_out <= 1'b0;
            ist_q      <= nxt_q;
          end
        end
        lfr_pkg::IS_RD:
        begin
          if (bit_q == 4'h8)
          begin
            sda_oe_out <= 1'b0;
            ist_q      <= lfr_pkg::IS_RACK;
          end
          else
          begin
            sh_q       <= {sh_q[6:0], 1'b0};
            sda_oe_out <= !sh_q[6];
          end
        end
        lfr_pkg::IS_IDLE:
          sda_oe_out <= 1'b0;
        default:
          ist_q <= lfr_pkg::IS_IDLE;
      endcase
    end
  end

  // Open-drain data pin only ever pulls low
  always_ff @(posedge clk_sys_in)
  begin
    sda_out <= 1'b0;
  end

  // Register file
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < `LFR_REG_COUNT; i++)
        regs_q[i] <= rst_val(i);
    end
    else if (wr_q && wa_q <= `LFR_REG_LAST)
    begin
      if (wa_q == `LFR_REG_EXTERNAL_PWM_INPUT)
        regs_q[wa_q] <= wd_q & `LFR_EXTERNAL_PWM_INPUT_MASK;
      else
        regs_q[wa_q] <= wd_q;
    end
  end

  // Link domain: reset capture and tick toggle from the sync pin clock
  always_ff @(posedge sync_clk_in)
  begin
    lrst1_q <= rst_in;
    lrst2_q <= lrst1_q;
  end
  always_ff @(posedge sync_clk_in)
  begin
    if (lrst2_q)
    begin
      lcnt_q <= 32'h0000_0000;
      ltgl_q <= 1'b0;
    end
    else if (lcnt_q >= 32'(LINK_DIV - 1))
    begin
      lcnt_q <= 32'h0000_0000;
      ltgl_q <= !ltgl_q;
    end
    else
      lcnt_q <= lcnt_q + 32'h0000_0001;
  end

  // Common fine tick from the selected clock source
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      tsy_q  <= 3'h0;
      fcnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else
    begin
      tsy_q <= {tsy_q[1:0], ltgl_q};
      if (chip[`LFR_BIT_CLKDIR])
      begin
        fcnt_q <= 32'h0000_0000;
        tick_q <= tsy_q[2] ^ tsy_q[1];
      end
      else if (fcnt_q >= 32'(FINE_CYC - 1))
      begin
        fcnt_q <= 32'h0000_0000;
        tick_q <= 1'b1;
      end
      else
      begin
        fcnt_q <= fcnt_q + 32'h0000_0001;
        tick_q <= 1'b0;
      end
    end
  end

  // Sync pin drive: input, low, or oscillator clock out
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      sync_oe_out <= 1'b1;
      sync_out    <= 1'b0;
    end
    else
    begin
      sync_oe_out <= !chip[`LFR_BIT_CLKDIR];
      sync_out    <= chip[`LFR_BIT_CLKOEN] && !chip[`LFR_BIT_CLKDIR] && !sync_out;
    end
  end

  // Clock-line-low shutdown and standby
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      scnt_q   <= 32'h0000_0000;
      scl_sd_q <= 1'b0;
      stby_q   <= 1'b1;
    end
    else
    begin
      if (scl_s || !chip[`LFR_BIT_PDEN])
      begin
        scnt_q   <= 32'h0000_0000;
        scl_sd_q <= 1'b0;
      end
      else if (scnt_q >= 32'(SCL_LOW_CYC))
        scl_sd_q <= 1'b1;
      else
        scnt_q <= scnt_q + 32'h0000_0001;
      stby_q <= !chip[`LFR_BIT_SOFTDN] || scl_sd_q;
    end
  end

  // Brightness PWM counter and current interpolation frame
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      pwm_q <= 8'h00;
      il_q  <= 2'h0;
    end
    else
    begin
      pwm_q <= pwm_q + 8'h01;
      il_q  <= il_q + 2'h1;
    end
  end

  // Flash engines, one per group
  for (genvar g = 0; g < 4; g++)
  begin : g_grp
    localparam int B = int'(`LFR_REG_GRP_BASE) + g * int'(`LFR_GRP_STRIDE);
    assign cfg[g] = {regs_q[B + int'(`LFR_GOFS_PERIOD)],
                     regs_q[B + int'(`LFR_GOFS_ON_TIMER_ONE)],
                     regs_q[B + int'(`LFR_GOFS_ON_TIMER_TWO)],
                     regs_q[B + int'(`LFR_GOFS_RAMP)],
                     regs_q[B + int'(`LFR_GOFS_DELAY)],
                     regs_q[`LFR_REG_SCALE][2*g+1 -: 2]};
    lfr_group u_grp
    (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .tick_in    (tick_q),
      .run_in     (chip[`LFR_BIT_AUTO] && !stby_q),
      .cfg_in     (cfg[g]),
      .tmd_in     (lfr_pkg::lfr_tmd_e'(chip[1:0])),
      .level_out  (lvl[g])
    );
  end

  // Channel outputs: mode select, PWM gate, current units
  for (genvar c = 0; c < 12; c++)
  begin : g_ch
    localparam int G = c / 3;
    localparam int K = c % 3;
    lfr_pkg::lfr_cmode_e md;
    logic [7:0]          lv;
    logic [7:0]          cur;
    assign md  = cmode(regs_q[int'(`LFR_REG_MODE_BASE) + G], K);
    assign cur = ((regs_q[int'(`LFR_REG_CURT_BASE) + c] > `LFR_CURT_MAX)
                  ? `LFR_CURT_MAX : regs_q[int'(`LFR_REG_CURT_BASE) + c]) + 8'h01;
    always_comb
    begin
      unique case (md)
        lfr_pkg::CM_OFF: lv = 8'h00;
        lfr_pkg::CM_ON:  lv = 8'hFF;
        lfr_pkg::CM_T1:  lv = lvl[G][0];
        lfr_pkg::CM_T2:  lv = lvl[G][1];
        lfr_pkg::CM_T3:  lv = lvl[G][2];
        default:         lv = 8'h00;
      endcase
    end
    always_ff @(posedge clk_sys_in)
    begin
      if (rst_in)
        chan_out[c] <= '0;
      else
      begin
        chan_out[c].drive <= !stby_q && (lv == 8'hFF || lv > pwm_q)
                             && (!regs_q[`LFR_REG_EXTERNAL_PWM_INPUT][G] || sy2_q[2]);
        chan_out[c].units <= cur[7:2] + {5'h00, il_q < cur[1:0]};
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      range_hi_out <= 1'b0;
      standby_out  <= 1'b1;
    end
    else
    begin
      range_hi_out <= chip[`LFR_BIT_IMAX];
      standby_out  <= stby_q;
    end
  end
endmodule : lfr_top
`default_nettype wire
